// [rtl/pgi_top.sv]
// Notes on behaviour
// (RULE1) Mask view bit 8 shows fault enable.
// (RULE2) Mask view bits 2..0 show generator enables.
// (RULE3) Raw view shows sources regardless of mask.
// (RULE4) Raw bit 8 set while fault asserting.
// (RULE5) Raw bits 2..0 follow generator requests.
// (RULE6) Fault latched until software clears it.
// (RULE7) Status bit set when source active, unmasked.
// (RULE8) Status bit 8 shows unmasked fault.
// (RULE9) Writing one to bit 8 clears fault.
// (RULE10) Writing one to bits 2..0 clears generator.
// (RULE11) Generator status bit summarises generator status.
// (RULE12) Fault level reads input; writing one forces fault.
// (RULE13) Reserved bits reset and read zero.
// (RULE14) Enable register write one sets mask.
// (RULE15) Disable register write one clears mask.
// (RULE16) Interrupt high while any status bit set.
// (RULE17) Zero writes and read-only writes do nothing.
module pgi_top (
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    // AXI4-Lite write address
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [pgi_pkg::ADDR_W-1:0]   s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    input  wire logic [pgi_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    // AXI4-Lite write response
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    output logic [1:0]                        s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    input  wire logic [pgi_pkg::ADDR_W-1:0]   s_axi_araddr,
    // AXI4-Lite read data
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    output logic [pgi_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    // Event sources
    input  wire logic [pgi_pkg::NGEN-1:0]     gen_irq,
    input  wire logic                         fault_in,
    // Results
    output logic                              irq,
    output logic [pgi_pkg::NGEN-1:0]          gen_irq_clear,
    output logic                              fault_active
);
    import pgi_pkg::*;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Write side: gather address and data, then answer
    typedef enum logic [0:0] {
        WS_COLLECT = 1'b0,                    // Waiting for address and data
        WS_RESP    = 1'b1                     // Response offered
    } pgi_wst_t;

    // Read side: idle or holding data
    typedef enum logic [0:0] {
        RS_IDLE    = 1'b0,                    // Ready for an address
        RS_DATA    = 1'b1                     // Data offered
    } pgi_rst_t;

    // Whole bus-side state
    typedef struct packed {
        pgi_wst_t           wst;              // Write phase
        logic               aw_got;           // Address captured
        logic               w_got;            // Data captured
        logic [ADDR_W-1:0]  awaddr;           // Captured address
        logic [DATA_W-1:0]  wdata;            // Captured data
        logic [3:0]         wstrb;            // Captured strobes
        logic [1:0]         bresp;            // Write answer
        pgi_rst_t           rst;              // Read phase
        logic [DATA_W-1:0]  rdata;            // Read data
        logic [1:0]         rresp;            // Read answer
    } pgi_axi_t;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pgi_axi_t           state_reg;            // Registered bus state
    pgi_axi_t           state_next;           // Next bus state
    pgi_irq_if          ctl ();               // Link to the event core
    logic               aw_take;              // Address handshake now
    logic               w_take;               // Data handshake now
    logic               have_aw;              // Address available
    logic               have_w;               // Data available
    logic [ADDR_W-1:0]  eff_addr;             // Address of this write
    logic [DATA_W-1:0]  eff_data;             // Data of this write
    logic [3:0]         eff_strb;             // Strobes of this write
    logic [DATA_W-1:0]  wbits;                // Data after lane masking
    logic [NSRC-1:0]    wsrc;                 // Data in source order

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Word match, ignoring the byte lane bits
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a[ADDR_W-1:2] == off[ADDR_W-1:2];
    endfunction : hit

    // Byte strobes expanded to a bit mask
    function automatic logic [DATA_W-1:0] lanes(input logic [3:0] s);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction : lanes

    // Answer for an address: every defined register is OKAY
    function automatic logic [1:0] resp_of(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = hit(a, OFF_EN_SET) | hit(a, OFF_EN_CLR) | hit(a, OFF_MASK_VIEW) |
             hit(a, OFF_RAW_VIEW) | hit(a, OFF_STAT_CLR) | hit(a, OFF_FAULT_LVL);
        return ok ? RESP_OKAY : RESP_SLVERR;
    endfunction : resp_of

    // ------------------------------------------------------------
    // Handshake outputs
    // ------------------------------------------------------------
    // Write address and write data are held off while a response is pending,
    // so at most one write is in flight
    always_comb begin
        s_axi_awready = (state_reg.wst == WS_COLLECT) && !state_reg.aw_got;
        s_axi_wready  = (state_reg.wst == WS_COLLECT) && !state_reg.w_got;
        s_axi_bvalid  = (state_reg.wst == WS_RESP);
        s_axi_arready = (state_reg.rst == RS_IDLE);
        s_axi_rvalid  = (state_reg.rst == RS_DATA);
    end

    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    // Address and data may come in either order or together;
    // the register effect lands on the edge where the second arrives
    always_comb begin
        aw_take  = s_axi_awvalid && s_axi_awready;
        w_take   = s_axi_wvalid && s_axi_wready;
        have_aw  = state_reg.aw_got || aw_take;
        have_w   = state_reg.w_got || w_take;
        eff_addr = state_reg.aw_got ? state_reg.awaddr : s_axi_awaddr;
        eff_data = state_reg.w_got ? state_reg.wdata : s_axi_wdata;
        eff_strb = state_reg.w_got ? state_reg.wstrb : s_axi_wstrb;
        // Unstrobed lanes carry no ones, so they change nothing
        wbits    = eff_data & lanes(eff_strb);
        wsrc     = reg_to_src(wbits);                    // Reserved bits dropped [RULE13]
    end

    // ------------------------------------------------------------
    // Next state and pulses toward the core
    // ------------------------------------------------------------
    always_comb begin
        state_next      = state_reg;
        ctl.en_set      = '0;
        ctl.en_clr      = '0;
        ctl.pend_clr    = '0;
        ctl.fault_force = 1'b0;
        case (state_reg.wst)
            WS_COLLECT: begin
                // Hold whichever half arrives first
                if (aw_take) begin
                    state_next.aw_got = 1'b1;
                    state_next.awaddr = s_axi_awaddr;
                end
                if (w_take) begin
                    state_next.w_got = 1'b1;
                    state_next.wdata = s_axi_wdata;
                    state_next.wstrb = s_axi_wstrb;
                end
                // Both halves present: perform the write once
                if (have_aw && have_w) begin
                    state_next.aw_got = 1'b0;
                    state_next.w_got  = 1'b0;
                    state_next.wst    = WS_RESP;
                    state_next.bresp  = resp_of(eff_addr);
                    // Only ones act; zeros leave state alone
                    if (hit(eff_addr, OFF_EN_SET)) begin
                        ctl.en_set = wsrc;                          // [RULE14] [RULE17]
                    end else if (hit(eff_addr, OFF_EN_CLR)) begin
                        ctl.en_clr = wsrc;                          // [RULE15] [RULE17]
                    end else if (hit(eff_addr, OFF_STAT_CLR)) begin
                        ctl.pend_clr = wsrc;                        // [RULE9] [RULE10] [RULE17]
                    end else if (hit(eff_addr, OFF_FAULT_LVL)) begin
                        ctl.fault_force = wbits[BIT_LEVEL];         // [RULE12]
                    end else begin
                        // Views and unmapped words: no effect
                        ctl.fault_force = 1'b0;                     // [RULE17]
                    end
                end
            end
            WS_RESP: begin
                // Response stands until the master takes it
                if (s_axi_bready) begin
                    state_next.wst = WS_COLLECT;
                end
            end
            default: begin
                state_next.wst = WS_COLLECT;
            end
        endcase

        case (state_reg.rst)
            RS_IDLE: begin
                // Capture the word on the address edge
                if (s_axi_arvalid) begin
                    state_next.rst   = RS_DATA;
                    state_next.rresp = resp_of(s_axi_araddr);
                    if (hit(s_axi_araddr, OFF_MASK_VIEW)) begin
                        state_next.rdata = src_to_reg(ctl.mask);   // [RULE1] [RULE2]
                    end else if (hit(s_axi_araddr, OFF_RAW_VIEW)) begin
                        state_next.rdata = src_to_reg(ctl.raw);    // [RULE3]
                    end else if (hit(s_axi_araddr, OFF_STAT_CLR)) begin
                        state_next.rdata = src_to_reg(ctl.pend);   // [RULE7] [RULE11]
                    end else if (hit(s_axi_araddr, OFF_FAULT_LVL)) begin
                        state_next.rdata = RESERVED_VAL;            // [RULE13]
                        state_next.rdata[BIT_LEVEL] = ctl.level;    // [RULE12]
                    end else begin
                        // Write-only and unmapped words read zero
                        state_next.rdata = RESERVED_VAL;            // [RULE13]
                    end
                end
            end
            RS_DATA: begin
                // Data stands until the master takes it
                if (s_axi_rready) begin
                    state_next.rst = RS_IDLE;
                end
            end
            default: begin
                state_next.rst = RS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Bus state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '{
                wst:    WS_COLLECT,
                aw_got: 1'b0,
                w_got:  1'b0,
                awaddr: '0,
                wdata:  '0,
                wstrb:  4'h0,
                bresp:  RESP_OKAY,
                rst:    RS_IDLE,
                rdata:  RESERVED_VAL,
                rresp:  RESP_OKAY
            };
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Event core
    // ------------------------------------------------------------
    // Mask, fault latch and interrupt line live in the core;
    // this module only decodes the bus
    pgi_irq_core u_core (
        .clk           (clk),
        .reset_n       (reset_n),
        .gen_irq       (gen_irq),
        .fault_in      (fault_in),
        .ctl           (ctl.core),
        .irq           (irq),
        .gen_irq_clear (gen_irq_clear),
        .fault_active  (fault_active)
    );

endmodule : pgi_top

// [rtl/pgi_pkg.sv]
package pgi_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 8;        // Byte address width
    localparam int          DATA_W          = 32;       // Register width
    localparam int          NSRC            = 4;        // Fault plus three generators
    localparam int          NGEN            = 3;        // Generator sources

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_EN_SET      = 8'h14;    // Write-one-to-enable
    localparam logic [7:0]  OFF_EN_CLR      = 8'h18;    // Write-one-to-disable
    localparam logic [7:0]  OFF_MASK_VIEW   = 8'h1C;    // Mask state, read only
    localparam logic [7:0]  OFF_RAW_VIEW    = 8'h20;    // Raw sources, read only
    localparam logic [7:0]  OFF_STAT_CLR    = 8'h24;    // Pending, write one to clear
    localparam logic [7:0]  OFF_FAULT_LVL   = 8'h28;    // Fault level, write one forces

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          BIT_FAULT       = 8;        // Fault bit in event registers
    localparam int          BIT_LEVEL       = 0;        // Level bit in fault register
    localparam int          SRC_FAULT       = 3;        // Fault index in source vector
    localparam logic [3:0]  MASK_RST        = 4'h0;     // All sources masked
    localparam logic [31:0] RESERVED_VAL    = 32'h0;    // Reserved bits read zero

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Source vector {fault, gen2, gen1, gen0} placed into register layout
    function automatic logic [31:0] src_to_reg(input logic [3:0] src);
        logic [31:0] v;
        v                  = RESERVED_VAL;
        v[BIT_FAULT]       = src[SRC_FAULT];
        v[NGEN-1:0]        = src[NGEN-1:0];
        return v;
    endfunction : src_to_reg

    // Register layout folded back into the source vector
    function automatic logic [3:0] reg_to_src(input logic [31:0] v);
        return {v[BIT_FAULT], v[NGEN-1:0]};
    endfunction : reg_to_src

endpackage : pgi_pkg

// [rtl/pgi_irq_if.sv]
interface pgi_irq_if;
    import pgi_pkg::*;

    logic [NSRC-1:0] en_set;        // One-cycle enable pulses
    logic [NSRC-1:0] en_clr;        // One-cycle disable pulses
    logic [NSRC-1:0] pend_clr;      // One-cycle clear pulses
    logic            fault_force;   // One-cycle software fault trigger
    logic [NSRC-1:0] mask;          // Current mask state
    logic [NSRC-1:0] raw;           // Raw source state
    logic [NSRC-1:0] pend;          // Masked pending state
    logic            level;         // Fault input level

    modport bus  (output en_set, en_clr, pend_clr, fault_force, input mask, raw, pend, level);
    modport core (input en_set, en_clr, pend_clr, fault_force, output mask, raw, pend, level);

endinterface : pgi_irq_if

// [rtl/pgi_irq_core.sv]
module pgi_irq_core (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic [pgi_pkg::NGEN-1:0] gen_irq,
    input  wire logic                 fault_in,
    pgi_irq_if.core                   ctl,
    output logic                      irq,
    output logic [pgi_pkg::NGEN-1:0]  gen_irq_clear,
    output logic                      fault_active
);
    import pgi_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NSRC-1:0] mask;        // Enable state per source
        logic            fault_latch; // Held fault event
        logic            irq;         // Registered interrupt line
        logic [NGEN-1:0] gen_clr;     // Clear pulses toward generators
    } pgi_core_t;

    pgi_core_t state_reg;             // Registered state
    pgi_core_t state_next;            // Next state
    logic      fault_event;           // Pin or software fault this cycle
    logic [NSRC-1:0] pend_now;        // Pending from current state

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next  = state_reg;
        fault_event = fault_in | ctl.fault_force;                        // [RULE12]
        // Set and clear come from distinct registers, so never together
        state_next.mask = (state_reg.mask | ctl.en_set) & ~ctl.en_clr;   // [RULE14] [RULE15]
        // A fault arriving with the clear wins, so no event is lost
        state_next.fault_latch = fault_event |
                                 (state_reg.fault_latch & ~ctl.pend_clr[SRC_FAULT]); // [RULE6] [RULE9]
        // Generator status lives in the generator; forward the clear
        state_next.gen_clr = ctl.pend_clr[NGEN-1:0];                     // [RULE10] [RULE11]
        pend_now = {state_reg.fault_latch, gen_irq} & state_reg.mask;    // [RULE7] [RULE16]
        state_next.irq = |pend_now;                                      // [RULE16]
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '{mask: MASK_RST, fault_latch: 1'b0, irq: 1'b0, gen_clr: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Views and outputs
    // ------------------------------------------------------------
    assign ctl.mask      = state_reg.mask;                                     // [RULE1] [RULE2]
    assign ctl.raw       = {state_reg.fault_latch | fault_in, gen_irq};        // [RULE3] [RULE4] [RULE5]
    assign ctl.pend      = pend_now;                                           // [RULE8]
    assign ctl.level     = fault_in;                                           // [RULE12]
    assign irq           = state_reg.irq;
    assign gen_irq_clear = state_reg.gen_clr;
    assign fault_active  = state_reg.fault_latch;

endmodule : pgi_irq_core

// [bench/pgi_irq_monitor.sv]
module pgi_irq_monitor
    import pgi_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [NGEN-1:0]   gen_irq,
    input wire logic              fault_in,
    input wire logic              irq,
    input wire logic [NGEN-1:0]   gen_irq_clear,
    input wire logic              fault_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Latch can only fall on the edge that completes a write
    sequence s_fault_drop;
        fault_active ##1 !fault_active;
    endsequence

    a_fault_sets:    assert property (fault_in |=> fault_active) else $error("fault latch missed");
    a_fault_clear:   assert property (s_fault_drop |-> s_axi_bvalid) else $error("fault dropped alone");
    a_irq_source:    assert property (irq |-> $past(fault_active || (|gen_irq))) else $error("irq no source");
    a_clr_single:    assert property (|gen_irq_clear |=> gen_irq_clear == '0) else $error("clear too long");
    a_resp_blocks:   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("bus not held");
    a_rdata_stands:  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
endmodule : pgi_irq_monitor

bind pgi_top pgi_irq_monitor i_pgi_irq_monitor (
    .clk           (clk),
    .reset_n       (reset_n),
    .s_axi_awready (s_axi_awready),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .gen_irq       (gen_irq),
    .fault_in      (fault_in),
    .irq           (irq),
    .gen_irq_clear (gen_irq_clear),
    .fault_active  (fault_active)
);

module pwm_global_irq_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pgi_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and bookkeeping
    // ------------------------------------------------------------
    localparam int MAX_CYCLES = 5000;   // Generous ceiling for a hang
    logic clk = 1'b0, reset_n = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, fault_active;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [2:0] gen_irq = 3'h0, gen_irq_clear, clr_seen;
    logic fault_in = 1'b0;
    int n_fail = 0, samples_checked = 0, cycles = 0;

    always #12.5 clk = ~clk;

    pgi_top i_pgi_top (
        .clk(clk), .reset_n(reset_n),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .gen_irq(gen_irq), .fault_in(fault_in),
        .irq(irq), .gen_irq_clear(gen_irq_clear), .fault_active(fault_active)
    );

    task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check_val

    // Both halves offered together; each released on its own handshake
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_wvalid <= 1'b1; s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF; s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready && !ad) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
            if (s_axi_wready && !wd) begin wd = 1'b1; s_axi_wvalid <= 1'b0; end
        end while (!(ad && wd));
        do @(posedge clk); while (!s_axi_bvalid);
        clr_seen = gen_irq_clear;   // Pulse stands in the response cycle
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic t_mask;
        axi_read(OFF_MASK_VIEW, rd, rr); check_val(rd, 32'h0);
        axi_write(OFF_EN_SET, 32'h107); axi_read(OFF_MASK_VIEW, rd, rr); check_val(rd, 32'h107);
        axi_write(OFF_EN_CLR, 32'h2); axi_read(OFF_MASK_VIEW, rd, rr); check_val(rd, 32'h105);
        axi_write(OFF_MASK_VIEW, 32'hFFFFFFFF); axi_read(OFF_MASK_VIEW, rd, rr); check_val(rd, 32'h105);
    endtask : t_mask

    task automatic t_gen;
        @(posedge clk); gen_irq <= 3'h3;
        axi_read(OFF_RAW_VIEW, rd, rr); check_val(rd, 32'h3);
        axi_read(OFF_STAT_CLR, rd, rr); check_val(rd, 32'h1);
        check_val({31'h0, irq}, 32'h1);
        axi_write(OFF_STAT_CLR, 32'h1); check_val({29'h0, clr_seen}, 32'h1);
        gen_irq <= 3'h2;   // Generator drops its request on the clear
        axi_read(OFF_STAT_CLR, rd, rr); check_val(rd, 32'h0);
        check_val({31'h0, irq}, 32'h0);
    endtask : t_gen

    task automatic t_fault;
        @(posedge clk); fault_in <= 1'b1;
        axi_read(OFF_FAULT_LVL, rd, rr); check_val(rd, 32'h1);
        fault_in <= 1'b0;
        axi_read(OFF_FAULT_LVL, rd, rr); check_val(rd, 32'h0);
        axi_read(OFF_RAW_VIEW, rd, rr); check_val(rd, 32'h102);
        axi_read(OFF_STAT_CLR, rd, rr); check_val(rd, 32'h100);
        check_val({31'h0, irq}, 32'h1);
        axi_write(OFF_STAT_CLR, 32'h0); axi_read(OFF_STAT_CLR, rd, rr); check_val(rd, 32'h100);
        axi_write(OFF_STAT_CLR, 32'h100); axi_read(OFF_STAT_CLR, rd, rr); check_val(rd, 32'h0);
        axi_write(OFF_FAULT_LVL, 32'h1); axi_read(OFF_STAT_CLR, rd, rr); check_val(rd, 32'h100);
        axi_write(OFF_STAT_CLR, 32'h100); axi_write(OFF_EN_CLR, 32'h107);
        axi_read(8'h40, rd, rr); check_val({rr, rd[29:0]}, {RESP_SLVERR, 30'h0});
        repeat (2) @(posedge clk); check_val({31'h0, irq}, 32'h0);
    endtask : t_fault

    task automatic report_and_stop;
        $display("Checks made %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // A hang counts as a mismatch and ends the run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == MAX_CYCLES) begin
            n_fail++;
            report_and_stop();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        t_mask();
        t_gen();
        t_fault();
        report_and_stop();
    end
endmodule : pwm_global_irq_status_tb_top
